// ===== event_generator_select_upper.sv
/*
  Upper-range event generator select router for all event channels.
  Assumes select codes come from the channel select registers elsewhere
  and all synchronous sources are already on mclk.
*/
// Operation
// - Codes 60h-64h route serial units 0-4 transfer clocks, synchronously, any channel.
// - Codes 68h and 69h route SPI units 0 and 1 host clock.
// - Timer A0 codes 80,81,84-86 select overflow, high underflow, compares.
// - Timer A1 uses the same events at codes offset by eight.
// - Timer B 0-3: even code capture flag, odd code overflow.
// - Capture event follows the timer's own flag timing one mclk later; router adds only that register stage.
// - Port pin events read zero when the pin input buffer is off.
// - Sources of absent instances in this variant give no event.
// - Each channel carries one selected generator; code zero carries nothing.
module event_generator_select_upper
  import evgen_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic [NUM_CHANNELS*8-1:0] channel_generator_select,
  input  variant_t                       variant,
  input  wire logic [NUM_SERIAL-1:0]     serial_transfer_clock,
  input  wire logic [NUM_SPI-1:0]        spi_host_clock,
  input  timer_a_ev_t                    timer_a_unit_zero,
  input  timer_a_ev_t                    timer_a_unit_one,
  input  timer_b_ev_t [NUM_TIMER_B-1:0]  timer_b_unit,
  input  timer_d_ev_t                    timer_d_unit_zero,
  input  wire logic [NUM_CHANNELS-1:0]   pin_event,
  input  wire logic [NUM_CHANNELS-1:0]   pin_select,
  input  wire logic [NUM_CHANNELS-1:0]   pin_buffer_enable,
  output logic      [NUM_CHANNELS-1:0]   sync_event,
  output logic      [NUM_CHANNELS-1:0]   channel_active
);

  // Timer A event by low code bits; unused codes give nothing
  function automatic logic pick_timer_a(input timer_a_ev_t t, input logic [2:0] s);
    logic r;
    r = 1'b0;
    case (s)
      TA_OVF:  r = t.overflow_or_low_underflow;
      TA_HIGH_BYTE_UNDERFLOW: r = t.high_byte_underflow;
      TA_CMP0: r = t.compare_match_zero;
      TA_CMP1: r = t.compare_match_one;
      TA_CMP2: r = t.compare_match_two;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [NUM_SERIAL-1:0]  serial_present;
  logic [NUM_TIMER_B-1:0] timer_b_present;
  logic [NUM_CHANNELS-1:0] next_sync_event;
  logic [NUM_CHANNELS-1:0] next_channel_active;
  logic [NUM_CHANNELS-1:0] async_event;

  // Absent instances are masked so a stray code is silent
  always_comb begin
    serial_present  = {variant.serial_unit_four, variant.serial_unit_three, 3'h7};
    timer_b_present = {variant.timer_b_unit_three, 3'h7};
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      logic [7:0] sel;
      logic       d_hit;
      logic       d_ev;
      logic       s_ev;
      logic       s_hit;
      assign sel = channel_generator_select[ch*8 +: 8];

      evgen_timer_d_path u_tdp (
        .sel               (sel),
        .timer_d_unit_zero (timer_d_unit_zero),
        .hit               (d_hit),
        .ev                (d_ev)
      );

      // Synchronous source mux, one generator per channel
      always_comb begin
        s_ev  = 1'b0;
        s_hit = 1'b0;
        if (sel == SEL_OFF) begin
          s_hit = 1'b0;
        end else if (sel >= SEL_SERIAL_BASE && sel <= SEL_SERIAL_LAST) begin
          s_hit = serial_present[sel[2:0]];
          s_ev  = serial_transfer_clock[sel[2:0]] & serial_present[sel[2:0]];
        end else if (sel >= SEL_SPI_BASE && sel <= SEL_SPI_LAST) begin
          s_hit = 1'b1;
          s_ev  = spi_host_clock[sel[0]];
        end else if ((sel & SEL_TIMER_A_MASK) == SEL_TIMER_A0) begin
          s_hit = 1'b1;
          s_ev  = pick_timer_a(timer_a_unit_zero, sel[2:0]);
        end else if ((sel & SEL_TIMER_A_MASK) == SEL_TIMER_A1) begin
          s_hit = variant.timer_a_unit_one;
          s_ev  = pick_timer_a(timer_a_unit_one, sel[2:0]) & variant.timer_a_unit_one;
        end else if (sel >= SEL_TIMER_B_BASE && sel <= SEL_TIMER_B_LAST) begin
          s_hit = timer_b_present[sel[2:1]];
          // Capture pulse is taken as the timer raises it, mode logic lives in the timer
          s_ev  = (sel[0] ? timer_b_unit[sel[2:1]].counter_overflow_event
                          : timer_b_unit[sel[2:1]].capture_flag_event) & timer_b_present[sel[2:1]];
        end
      end

      // Async path, on no output: pin path gated by buffer enable, or timer D
      always_comb begin
        async_event[ch] = 1'b0;
        if (pin_select[ch]) begin
          async_event[ch] = pin_event[ch] & pin_buffer_enable[ch];
        end else if (d_hit) begin
          async_event[ch] = d_ev;
        end
        next_sync_event[ch]     = s_ev;
        next_channel_active[ch] = s_hit | d_hit;
      end
    end
  endgenerate

  // Registered synchronous events and activity
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_event     <= '0;
      channel_active <= '0;
    end else begin
      sync_event     <= next_sync_event;
      channel_active <= next_channel_active;
    end
  end

  // Timer D and pin events are async; registered copy async_seen feeds no output
  logic [NUM_CHANNELS-1:0] async_seen;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      async_seen <= '0;
    end else begin
      async_seen <= async_event;
    end
  end

  a_off_silent: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_OFF) |=> !sync_event[0] && !channel_active[0])
    else $error("channel 0 off but active");
  a_spi_route: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_SPI_BASE) |=> sync_event[0] == $past(spi_host_clock[0]))
    else $error("spi clock not routed");
  a_serial_route: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_SERIAL_BASE) |=> sync_event[0] == $past(serial_transfer_clock[0]))
    else $error("serial clock not routed");
  a_ta0_ovf: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_TIMER_A0) |=>
      sync_event[0] == $past(timer_a_unit_zero.overflow_or_low_underflow))
    else $error("timer a0 overflow not routed");
  a_ta1_absent: assert property (@(posedge mclk) disable iff (rst)
    ((channel_generator_select[7:0] & SEL_TIMER_A_MASK) == SEL_TIMER_A1 && !variant.timer_a_unit_one)
      |=> !sync_event[0] && !channel_active[0])
    else $error("absent timer a1 routed");
  a_tb_capture_flag_event: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_TIMER_B_BASE) |=>
      sync_event[0] == $past(timer_b_unit[0].capture_flag_event))
    else $error("timer b capture not routed");
  a_pin_gate: assert property (@(posedge mclk) disable iff (rst)
    (pin_select[0] && !pin_buffer_enable[0]) |=> !async_seen[0])
    else $error("pin event with buffer off");
  a_td_active: assert property (@(posedge mclk) disable iff (rst)
    (channel_generator_select[7:0] == SEL_TIMER_D_BASE) |=> channel_active[0] && !sync_event[0])
    else $error("timer d code not active");
endmodule // event_generator_select_upper

// ===== evgen_pkg.sv
/*
  Package for the upper-range event generator select decoder.
  Holds select codes, source indices, struct carriers and presence straps.
  Assumes one peripheral clock; event inputs synchronous except timer D and pins.
*/
package evgen_pkg;
  localparam int          NUM_CHANNELS     = 10;
  localparam int          SEL_W            = 8;
  localparam logic [7:0]  SEL_OFF          = 8'h00;
  localparam logic [7:0]  SEL_SERIAL_BASE  = 8'h60;
  localparam logic [7:0]  SEL_SERIAL_LAST  = 8'h64;
  localparam logic [7:0]  SEL_SPI_BASE     = 8'h68;
  localparam logic [7:0]  SEL_SPI_LAST     = 8'h69;
  localparam logic [7:0]  SEL_TIMER_A0     = 8'h80;
  localparam logic [7:0]  SEL_TIMER_A1     = 8'h88;
  localparam logic [7:0]  SEL_TIMER_A_MASK = 8'hF8;
  localparam logic [2:0]  TA_OVF           = 3'h0;
  localparam logic [2:0]  TA_HIGH_BYTE_UNDERFLOW          = 3'h1;
  localparam logic [2:0]  TA_CMP0          = 3'h4;
  localparam logic [2:0]  TA_CMP1          = 3'h5;
  localparam logic [2:0]  TA_CMP2          = 3'h6;
  localparam logic [7:0]  SEL_TIMER_B_BASE = 8'hA0;
  localparam logic [7:0]  SEL_TIMER_B_LAST = 8'hA7;
  localparam logic [7:0]  SEL_TIMER_D_BASE = 8'hB0;
  localparam logic [7:0]  SEL_TIMER_D_LAST = 8'hB3;
  localparam int          NUM_SERIAL       = 5;
  localparam int          NUM_SPI          = 2;
  localparam int          NUM_TIMER_B      = 4;

  typedef struct packed {
    logic overflow_or_low_underflow;
    logic high_byte_underflow;
    logic compare_match_zero;
    logic compare_match_one;
    logic compare_match_two;
  } timer_a_ev_t;

  typedef struct packed {
    logic capture_flag_event;
    logic counter_overflow_event;
  } timer_b_ev_t;

  typedef struct packed {
    logic compare_b_clear_match;
    logic compare_a_set_match;
    logic compare_b_set_match;
    logic programmable_event_out;
  } timer_d_ev_t;

  // Which optional instances exist in this pin-count variant
  typedef struct packed {
    logic serial_unit_three;
    logic serial_unit_four;
    logic timer_a_unit_one;
    logic timer_b_unit_three;
  } variant_t;
endpackage

// ===== evgen_timer_d_path.sv
/*
  Timer D event path: picks one of the four timer D outputs.
  Combinational on purpose, these sources are asynchronous and must
  not be delayed by the peripheral clock.
*/
module evgen_timer_d_path
  import evgen_pkg::*;
(
  input  wire logic [7:0] sel,
  input  timer_d_ev_t     timer_d_unit_zero,
  output logic            hit,
  output logic            ev
);
  // Code decode for the B0..B3 range
  always_comb begin
    hit = (sel >= SEL_TIMER_D_BASE) && (sel <= SEL_TIMER_D_LAST);
    ev  = 1'b0;
    if (hit) begin
      case (sel[1:0])
        2'h0: ev = timer_d_unit_zero.compare_b_clear_match;
        2'h1: ev = timer_d_unit_zero.compare_a_set_match;
        2'h2: ev = timer_d_unit_zero.compare_b_set_match;
        default: ev = timer_d_unit_zero.programmable_event_out;
      endcase
    end
  end
endmodule // evgen_timer_d_path

// ===== event_source_model.sv
/*
  Partner model of the peripheral event outputs feeding the router.
  Assumes the bench names one source index and a fire strobe on mclk.
*/
module event_source_model
  import evgen_pkg::*;
(
  input  wire logic                     fire,
  input  wire logic [4:0]               src,
  output logic [NUM_SERIAL-1:0]         serial_transfer_clock,
  output logic [NUM_SPI-1:0]            spi_host_clock,
  output timer_a_ev_t                   ta0,
  output timer_a_ev_t                   ta1,
  output timer_b_ev_t [NUM_TIMER_B-1:0] tb,
  output timer_d_ev_t                   td
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [28:0] hot;
  // One output strobes per event, as a real generator does
  assign hot = fire ? (29'h1 << src) : 29'h0;
  assign serial_transfer_clock = hot[4:0];
  assign spi_host_clock = hot[6:5];
  assign ta0 = {hot[7], hot[8], hot[9], hot[10], hot[11]};
  assign ta1 = {hot[12], hot[13], hot[14], hot[15], hot[16]};
  // Capture strobe comes when the bench fires that unit's capture source index
  assign tb = {hot[23], hot[24], hot[21], hot[22], hot[19], hot[20], hot[17], hot[18]};
  assign td = {hot[25], hot[26], hot[27], hot[28]};
endmodule // event_source_model

// ===== event_generator_select_upper_tb_top.sv
/*
  Self-checking bench for the upper-range event select router.
  Assumes the event source model and a 100 MHz mclk.
*/
module event_generator_select_upper_tb_top;
  import evgen_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      mclk, rst, fire;
  logic [4:0]                src;
  logic [NUM_CHANNELS*8-1:0] sel_bus;
  variant_t                  variant;
  logic [NUM_SERIAL-1:0]     stc;
  logic [NUM_SPI-1:0]        shc;
  timer_a_ev_t               ta0, ta1;
  timer_b_ev_t [3:0]         tb;
  timer_d_ev_t               td;
  logic [NUM_CHANNELS-1:0]   pin_event, pin_select, pin_buffer_enable, sync_event, channel_active;
  int                        failures, total_checks, i;
  int                        offs [5] = '{0, 1, 4, 5, 6};

  event_source_model event_source_model_i (.fire(fire), .src(src), .serial_transfer_clock(stc),
    .spi_host_clock(shc), .ta0(ta0), .ta1(ta1), .tb(tb), .td(td));
  event_generator_select_upper event_generator_select_upper_i (.mclk(mclk), .rst(rst),
    .channel_generator_select(sel_bus), .variant(variant), .serial_transfer_clock(stc),
    .spi_host_clock(shc), .timer_a_unit_zero(ta0), .timer_a_unit_one(ta1), .timer_b_unit(tb),
    .timer_d_unit_zero(td), .pin_event(pin_event), .pin_select(pin_select),
    .pin_buffer_enable(pin_buffer_enable), .sync_event(sync_event), .channel_active(channel_active));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One strobe from source s with code on channel ch; the pulse must last one cycle only
  task automatic route(input logic [7:0] code, input int s, input int ch, input logic ev, input logic act);
    logic [9:0] one;
    one = 10'h001 << ch;
    @(posedge mclk);
    sel_bus <= 80'(code) << (8 * ch);
    src <= 5'(s);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    #1;
    check(ev ? one : 10'h000, sync_event);
    check(act ? one : 10'h000, channel_active);
    @(posedge mclk);
    #1;
    check(10'h000, sync_event);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset, then each source family in turn
  initial begin
    rst = 1'b1; fire = 1'b0; src = 5'h00; sel_bus = '0; variant = 4'hF;
    pin_event = '0; pin_select = '0; pin_buffer_enable = '0;
    failures = 0; total_checks = 0;
    repeat (4) @(posedge mclk);
    check(10'h000, channel_active);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) route(SEL_SERIAL_BASE + 8'(i), i, i, 1'b1, 1'b1);
    for (i = 0; i < 2; i++) route(SEL_SPI_BASE + 8'(i), 5 + i, 5 + i, 1'b1, 1'b1);
    for (i = 0; i < 5; i++) route(SEL_TIMER_A0 + 8'(offs[i]), 7 + i, i, 1'b1, 1'b1);
    for (i = 0; i < 5; i++) route(SEL_TIMER_A1 + 8'(offs[i]), 12 + i, 5 + i, 1'b1, 1'b1);
    for (i = 0; i < 8; i++) route(SEL_TIMER_B_BASE + 8'(i), 17 + i, i, 1'b1, 1'b1);
    for (i = 0; i < 4; i++) route(SEL_TIMER_D_BASE + 8'(i), 25 + i, 6 + i, 1'b0, 1'b1);
    route(8'h00, 0, 0, 1'b0, 1'b0);
    route(8'h65, 0, 9, 1'b0, 1'b0);
    route(8'h60, 1, 8, 1'b0, 1'b1);
    @(posedge mclk) variant <= 4'h0;
    route(8'h63, 3, 1, 1'b0, 1'b0);
    route(8'h64, 4, 2, 1'b0, 1'b0);
    route(8'h88, 12, 3, 1'b0, 1'b0);
    route(8'hA6, 23, 4, 1'b0, 1'b0);
    // Pin level high but its input buffer off
    @(posedge mclk);
    variant <= 4'hF;
    sel_bus <= '0;
    pin_event <= '1;
    pin_select <= '1;
    repeat (2) @(posedge mclk);
    #1;
    check(10'h000, sync_event);
    check(10'h000, event_generator_select_upper_i.async_seen);
    // Same pin level with the buffer on must now pass through
    @(posedge mclk);
    pin_buffer_enable <= '1;
    repeat (2) @(posedge mclk);
    #1;
    check(10'h3FF, event_generator_select_upper_i.async_seen);
    report_and_stop();
  end
endmodule // event_generator_select_upper_tb_top
